/* clock_fullscale_map.vh */
`ifndef CLOCK_FULLSCALE_MAP_VH
`define CLOCK_FULLSCALE_MAP_VH

// ==========================================================================
// register byte addresses
`define ADDR_SYSREF_INPUT_CONTROL 8'h2A
`define ADDR_SAMPLING_CLOCK_TUNE  8'h2B
`define ADDR_EDGE_POS_B0          8'h2C
`define ADDR_EDGE_POS_B1          8'h2D
`define ADDR_EDGE_POS_B2          8'h2E
`define ADDR_FS_CODE_A_LO         8'h30
`define ADDR_FS_CODE_A_HI         8'h31
`define ADDR_FS_CODE_B_LO         8'h32
`define ADDR_FS_CODE_B_HI         8'h33

// ==========================================================================
// reset values
`define RST_SYSREF_INPUT_CONTROL  8'h00
`define RST_SAMPLING_CLOCK_TUNE   8'h11
`define RST_EDGE_POS              24'h000000
`define RST_FS_CODE               16'hA000
`define READ_UNMAPPED             8'h00
`define RST_GAIN_HIGH             1'b1
`define RST_CLK_DELAY             2'h1

// ==========================================================================
// field positions, sysref input control
`define BIT_SYSREF_INVERT         0
`define BIT_SYSREF_DC_IN          1
`define BIT_DEVCLK_DC_IN          2
`define BIT_SYSREF_MARKER         3

// field positions, sampling clock tuning
`define MSB_CLK_DELAY             1
`define LSB_CLK_DELAY             0
`define BIT_NOISE_SUPPRESS        2
`define BIT_GAIN_HIGH             4

// ==========================================================================
// widths and delay line
`define SAMPLE_W                  16
`define EDGE_POS_W                24
`define FS_CODE_W                 16
`define DELAY_SEL_W               4
`define DELAY_TAPS                16

`endif

/* pin_sync2.v */
`timescale 1ns/1ps
`default_nettype none

// two flip-flop synchroniser for a level from outside the clock domain
module pin_sync2 (
  input  wire       clock,    // system clock
  input  wire       rst,      // async reset, active high
  input  wire       async_in, // level from a pin
  output reg        sync_out  // synchronised level
);

  reg meta_r;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // pin_sync2

`default_nettype wire

/* sysref_clock_fullscale_config.v */
// Function
// [R1] both marker enables put sysref in sample lsb
// [R2] lsb insertion only when decimation is one
// [R3] invert bit flips sysref before alignment use
// [R4] bits 2 and 1 select dc input modes
// [R5] bit 4 sets high converter gain, resets one
// [R6] software should set noise suppression bit 2
// [R7] one-hot sample clock delay, resets to 0x1
// [R8] sampling clock tuning resets to 0x11
// [R9] edge position reads back 24-bit status
// [R10] edge position read-only, meaningful after capture
// [R11] software picks delay select from position
// [R12] code a sets range a, resets 0xA000
// [R13] 0x2000 minimum, 0xFFFF maximum range code
// [R14] software avoids codes below 0x2000
// [R15] code b at 0x32, resets 0xA000
// [R16] delay select picks sysref capture delay tap
// [R17] otherwise lsb carries ordinary conversion data
`timescale 1ns/1ps
`default_nettype none
`include "clock_fullscale_map.vh"

module sysref_clock_fullscale_config (
  input  wire                         clock,                        // 25 MHz system clock
  input  wire                         rst,                          // async reset, active high
  input  wire                         reg_wr_en,                    // register byte write strobe
  input  wire                         reg_rd_en,                    // register byte read strobe
  input  wire [7:0]                   reg_addr,                     // register byte address
  input  wire [7:0]                   reg_wr_data,                  // register write byte
  output reg  [7:0]                   reg_rd_data,                  // register read byte
  output reg                          reg_rd_valid,                 // read byte valid pulse
  input  wire                         sysref_pin,                   // sysref alignment input level
  input  wire                         marker_output_enable,         // general marker output enable
  input  wire                         decimation_is_one,            // converter runs with D=1
  input  wire [`DELAY_SEL_W-1:0]      sysref_delay_select,          // sysref capture delay tap
  input  wire [`EDGE_POS_W-1:0]       edge_detector_status,         // raw edge window status
  input  wire [`SAMPLE_W-1:0]         sample_in,                    // conversion sample
  input  wire                         sample_in_valid,              // conversion sample valid
  output reg  [`SAMPLE_W-1:0]         sample_out,                   // serial-link output sample
  output reg                          sample_out_valid,             // output sample valid
  output reg                          sysref_aligned,               // sysref after polarity and delay
  output reg                          sysref_captured,              // a sysref capture has happened
  output reg                          sysref_dc_input_enable,       // dc-coupled sysref input mode
  output reg                          device_clock_dc_input_enable, // dc-coupled device clock mode
  output reg                          clock_converter_gain_high,    // converter feedback gain high
  output reg                          analog_supply_noise_suppress, // supply noise suppression on
  output reg  [1:0]                   sample_clock_delay,           // one-hot sample clock delay
  output reg  [`FS_CODE_W-1:0]        full_scale_code_a,            // range code input a
  output reg  [`FS_CODE_W-1:0]        full_scale_code_b             // range code input b
);

  // ==========================================================================
  // register storage
  reg  [7:0]                sysref_input_control_r;
  reg  [7:0]                sampling_clock_tuning_r;
  reg  [`EDGE_POS_W-1:0]    sysref_edge_position_r;
  reg  [`FS_CODE_W-1:0]     fs_code_a_r;
  reg  [`FS_CODE_W-1:0]     fs_code_b_r;
  reg  [7:0]                rd_data_nxt;

  // ==========================================================================
  // sysref path
  wire                      sysref_sync;
  reg  [`DELAY_TAPS-1:0]    sysref_taps_r;
  reg                       sysref_tap_prev_r;
  wire                      sysref_polar;
  wire                      sysref_tap;
  wire                      sysref_rise;
  wire                      marker_active;

  pin_sync2 u_sysref_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (sysref_pin),
    .sync_out (sysref_sync)
  );

  // polarity applied before the signal is used for alignment
  assign sysref_polar = sysref_sync ^ sysref_input_control_r[`BIT_SYSREF_INVERT]; // [R3]

  // tap 0 is the undelayed sample, higher taps add one cycle each
  assign sysref_tap  = sysref_taps_r[sysref_delay_select]; // [R16]
  assign sysref_rise = sysref_tap & ~sysref_tap_prev_r;

  // insertion needs both enables and the non-decimating path
  assign marker_active = sysref_input_control_r[`BIT_SYSREF_MARKER] & marker_output_enable // [R1]
                         & decimation_is_one; // [R2]

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sysref_taps_r     <= {`DELAY_TAPS{1'b0}};
      sysref_tap_prev_r <= 1'b0;
      sysref_aligned    <= 1'b0;
    end else begin
      sysref_taps_r     <= {sysref_taps_r[`DELAY_TAPS-2:0], sysref_polar};
      sysref_tap_prev_r <= sysref_tap;
      sysref_aligned    <= sysref_tap;
    end
  end

  // ==========================================================================
  // edge position capture
  // status is taken at the chosen tap's rising edge, the point software tunes
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sysref_edge_position_r <= `RST_EDGE_POS;
      sysref_captured        <= 1'b0;
    end else if (sysref_rise) begin
      sysref_edge_position_r <= edge_detector_status; // [R9]
      sysref_captured        <= 1'b1; // [R10]
    end
  end

  // ==========================================================================
  // output sample lsb marker
  // the marker bit is the delayed tap, so it lines up with the alignment point
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sample_out       <= {`SAMPLE_W{1'b0}};
      sample_out_valid <= 1'b0;
    end else begin
      sample_out_valid <= sample_in_valid;
      if (marker_active) begin
        sample_out <= {sample_in[`SAMPLE_W-1:1], sysref_tap}; // [R1]
      end else begin
        sample_out <= sample_in; // [R17]
      end
    end
  end

  // ==========================================================================
  // register writes; edge position bytes ignore writes
  // reserved bits are kept and read back as written
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sysref_input_control_r  <= `RST_SYSREF_INPUT_CONTROL; // [R3] [R4]
      sampling_clock_tuning_r <= `RST_SAMPLING_CLOCK_TUNE; // [R5] [R7] [R8]
      fs_code_a_r             <= `RST_FS_CODE; // [R12]
      fs_code_b_r             <= `RST_FS_CODE; // [R15]
    end else if (reg_wr_en) begin
      case (reg_addr)
        `ADDR_SYSREF_INPUT_CONTROL: begin
          sysref_input_control_r <= reg_wr_data;
        end
        `ADDR_SAMPLING_CLOCK_TUNE: begin
          sampling_clock_tuning_r <= reg_wr_data;
        end
        `ADDR_FS_CODE_A_LO: begin
          fs_code_a_r[7:0] <= reg_wr_data; // [R12] [R13]
        end
        `ADDR_FS_CODE_A_HI: begin
          fs_code_a_r[15:8] <= reg_wr_data; // [R12] [R13]
        end
        `ADDR_FS_CODE_B_LO: begin
          fs_code_b_r[7:0] <= reg_wr_data; // [R15]
        end
        `ADDR_FS_CODE_B_HI: begin
          fs_code_b_r[15:8] <= reg_wr_data; // [R15]
        end
        `ADDR_EDGE_POS_B0, `ADDR_EDGE_POS_B1, `ADDR_EDGE_POS_B2: begin
          sysref_edge_position_r <= sysref_edge_position_r; // [R10]
        end
        default: begin
          fs_code_b_r <= fs_code_b_r;
        end
      endcase
    end
  end

  // ==========================================================================
  // register reads, one cycle after the strobe
  always @* begin
    case (reg_addr)
      `ADDR_SYSREF_INPUT_CONTROL: rd_data_nxt = sysref_input_control_r;
      `ADDR_SAMPLING_CLOCK_TUNE:  rd_data_nxt = sampling_clock_tuning_r;
      `ADDR_EDGE_POS_B0:          rd_data_nxt = sysref_edge_position_r[7:0]; // [R9]
      `ADDR_EDGE_POS_B1:          rd_data_nxt = sysref_edge_position_r[15:8]; // [R9]
      `ADDR_EDGE_POS_B2:          rd_data_nxt = sysref_edge_position_r[23:16]; // [R9]
      `ADDR_FS_CODE_A_LO:         rd_data_nxt = fs_code_a_r[7:0];
      `ADDR_FS_CODE_A_HI:         rd_data_nxt = fs_code_a_r[15:8];
      `ADDR_FS_CODE_B_LO:         rd_data_nxt = fs_code_b_r[7:0];
      `ADDR_FS_CODE_B_HI:         rd_data_nxt = fs_code_b_r[15:8];
      default:                    rd_data_nxt = `READ_UNMAPPED;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= rd_data_nxt;
      end
    end
  end

  // ==========================================================================
  // configuration outputs, registered copies of the fields
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sysref_dc_input_enable       <= 1'b0;
      device_clock_dc_input_enable <= 1'b0;
      clock_converter_gain_high    <= `RST_GAIN_HIGH; // [R5]
      analog_supply_noise_suppress <= 1'b0;
      sample_clock_delay           <= `RST_CLK_DELAY; // [R7]
      full_scale_code_a            <= `RST_FS_CODE;
      full_scale_code_b            <= `RST_FS_CODE;
    end else begin
      sysref_dc_input_enable       <= sysref_input_control_r[`BIT_SYSREF_DC_IN]; // [R4]
      device_clock_dc_input_enable <= sysref_input_control_r[`BIT_DEVCLK_DC_IN]; // [R4]
      clock_converter_gain_high    <= sampling_clock_tuning_r[`BIT_GAIN_HIGH]; // [R5]
      analog_supply_noise_suppress <= sampling_clock_tuning_r[`BIT_NOISE_SUPPRESS];
      sample_clock_delay           <= sampling_clock_tuning_r[`MSB_CLK_DELAY:`LSB_CLK_DELAY]; // [R7]
      full_scale_code_a            <= fs_code_a_r; // [R12]
      full_scale_code_b            <= fs_code_b_r; // [R15]
    end
  end

endmodule // sysref_clock_fullscale_config

`default_nettype wire

/* sysref_cfg_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module sysref_cfg_checker (
  input wire logic        clock,                     // clock
  input wire logic        rst,                       // reset
  input wire logic        reg_wr_en,                 // write strobe
  input wire logic        reg_rd_en,                 // read strobe
  input wire logic [7:0]  reg_addr,                  // address
  input wire logic [7:0]  reg_wr_data,               // write byte
  input wire logic [7:0]  reg_rd_data,               // read byte
  input wire logic        reg_rd_valid,              // read valid
  input wire logic        marker_output_enable,      // marker enable
  input wire logic        decimation_is_one,         // no decimation
  input wire logic [15:0] sample_in,                 // sample in
  input wire logic        sample_in_valid,           // sample valid
  input wire logic [15:0] sample_out,                // sample out
  input wire logic        sysref_captured,           // capture seen
  input wire logic        sysref_dc_input_enable,    // dc mode
  input wire logic        clock_converter_gain_high, // gain
  input wire logic [1:0]  sample_clock_delay,        // delay
  input wire logic [15:0] full_scale_code_a,         // code a
  input wire logic [15:0] full_scale_code_b          // code b
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ==========================================
  // register port, configuration outputs and sample lsb
  property p_rd_answer;
    reg_rd_en |=> reg_rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_pos_blank;
    reg_rd_en && reg_addr >= 8'h2C && reg_addr <= 8'h2E && !sysref_captured |=> reg_rd_data == 8'h00;
  endproperty
  a_pos_blank: assert property (p_pos_blank) else $error("edge position nonzero before capture");
  property p_tune_reset;
    $fell(rst) |-> clock_converter_gain_high && sample_clock_delay == 2'b01;
  endproperty
  a_tune_reset: assert property (p_tune_reset) else $error("tuning reset value wrong");
  property p_fs_reset;
    $fell(rst) |-> full_scale_code_a == 16'hA000 && full_scale_code_b == 16'hA000;
  endproperty
  a_fs_reset: assert property (p_fs_reset) else $error("range code reset wrong");
  property p_dc_write;
    reg_wr_en && reg_addr == 8'h2A |=> ##1 sysref_dc_input_enable == $past(reg_wr_data[1], 2);
  endproperty
  a_dc_write: assert property (p_dc_write) else $error("dc mode not following write");
  property p_delay_write;
    reg_wr_en && reg_addr == 8'h2B |=> ##1 sample_clock_delay == $past(reg_wr_data[1:0], 2);
  endproperty
  a_delay_write: assert property (p_delay_write) else $error("delay not following write");
  property p_gain_write;
    reg_wr_en && reg_addr == 8'h2B |=> ##1 clock_converter_gain_high == $past(reg_wr_data[4], 2);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain not following write");
  property p_marker_off;
    !marker_output_enable && sample_in_valid |=> sample_out == $past(sample_in);
  endproperty
  a_marker_off: assert property (p_marker_off) else $error("lsb altered with marker off");
  property p_decim_off;
    !decimation_is_one && sample_in_valid |=> sample_out == $past(sample_in);
  endproperty
  a_decim_off: assert property (p_decim_off) else $error("lsb altered while decimating");

  c_tune_write: cover property (reg_wr_en && reg_addr == 8'h2B);
  c_marker_on: cover property (marker_output_enable && decimation_is_one && sample_in_valid);
  c_capture: cover property ($rose(sysref_captured));
endmodule // sysref_cfg_checker

`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wr_data = 8'h00;
  logic        sysref_pin = 1'b0;
  logic        marker_output_enable = 1'b0;
  logic        decimation_is_one = 1'b0;
  logic [3:0]  sysref_delay_select = 4'h0;
  logic [23:0] edge_detector_status = 24'hABCDEF;
  logic [15:0] sample_in = 16'h0000;
  logic        sample_in_valid = 1'b1;
  wire  [7:0]  reg_rd_data;
  wire         reg_rd_valid, sample_out_valid, sysref_aligned, sysref_captured;
  wire         sysref_dc_input_enable, device_clock_dc_input_enable;
  wire         clock_converter_gain_high, analog_supply_noise_suppress;
  wire  [1:0]  sample_clock_delay;
  wire  [15:0] sample_out, full_scale_code_a, full_scale_code_b;
  int          error_cnt = 0;
  int          checked = 0;

  always #20 clock = ~clock;

  sysref_clock_fullscale_config u_sysref_clock_fullscale_config (
    .clock, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .reg_rd_valid,
    .sysref_pin, .marker_output_enable, .decimation_is_one, .sysref_delay_select,
    .edge_detector_status, .sample_in, .sample_in_valid, .sample_out, .sample_out_valid,
    .sysref_aligned, .sysref_captured, .sysref_dc_input_enable, .device_clock_dc_input_enable,
    .clock_converter_gain_high, .analog_supply_noise_suppress, .sample_clock_delay,
    .full_scale_code_a, .full_scale_code_b);

  // ==========================================
  // shared tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wr_data = d;
    @(negedge clock);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd_en = 1'b0;
    chk(reg_rd_valid, 1'b1, "read valid");
    chk(reg_rd_data, exp, "read data");
  endtask

  task automatic sample(input logic [15:0] d, input logic [15:0] exp);
    @(negedge clock);
    sample_in = d;
    @(negedge clock);
    chk(sample_out, exp, "sample out");
    chk(sample_out_valid, 1'b1, "sample valid");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic reset_values;
    rd(8'h2A, 8'h00);
    rd(8'h2B, 8'h11);
    rd(8'h31, 8'hA0);
    rd(8'h32, 8'h00);
    rd(8'h33, 8'hA0);
    rd(8'h2E, 8'h00);
    rd(8'h40, 8'h00);
    chk(clock_converter_gain_high, 1'b1, "gain");
    chk(sample_clock_delay, 2'b01, "delay");
  endtask

  task automatic config_writes;
    wr(8'h2A, 8'h06);
    wr(8'h2B, 8'h06);
    wr(8'h30, 8'h00);
    wr(8'h31, 8'h20);
    wr(8'h32, 8'hFF);
    wr(8'h33, 8'hFF);
    wr(8'h2C, 8'h55);
    chk(sysref_dc_input_enable, 1'b1, "sysref dc");
    chk(device_clock_dc_input_enable, 1'b1, "clock dc");
    chk(clock_converter_gain_high, 1'b0, "gain");
    chk(analog_supply_noise_suppress, 1'b1, "noise");
    chk(sample_clock_delay, 2'b10, "delay");
    chk(full_scale_code_a, 16'h2000, "code a");
    chk(full_scale_code_b, 16'hFFFF, "code b");
    rd(8'h2B, 8'h06);
    rd(8'h2C, 8'h00);
  endtask

  task automatic sysref_path;
    int n;
    for (int k = 0; k <= 5; k += 5) begin
      sysref_pin = 1'b0;
      sysref_delay_select = k[3:0];
      edge_detector_status = (k == 0) ? 24'hABCDEF : 24'h13579B;
      repeat (24) @(negedge clock);
      sysref_pin = 1'b1;
      n = 0;
      while (sysref_aligned !== 1'b1 && n < 40) begin
        @(negedge clock);
        n++;
      end
      chk(n, 4 + k, "align delay");
      if (n == 40)
        complete_run;
      if (k == 0)
        rd(8'h2C, 8'hEF);
    end
    chk(sysref_captured, 1'b1, "captured");
    rd(8'h2C, 8'h9B);
    rd(8'h2D, 8'h57);
    rd(8'h2E, 8'h13);
  endtask

  task automatic marker_insert;
    wr(8'h2A, 8'h08);
    marker_output_enable = 1'b1;
    decimation_is_one = 1'b1;
    sample(16'h1234, 16'h1235);
    decimation_is_one = 1'b0;
    sample(16'h1234, 16'h1234);
    decimation_is_one = 1'b1;
    marker_output_enable = 1'b0;
    sample(16'h1234, 16'h1234);
    marker_output_enable = 1'b1;
    wr(8'h2A, 8'h09);
    repeat (12) @(negedge clock);
    sample(16'hFFFF, 16'hFFFE);
    wr(8'h2A, 8'h01);
    sample(16'h0F0F, 16'h0F0F);
    sample_in_valid = 1'b0;
    @(negedge clock);
    chk(sample_out_valid, 1'b0, "sample valid low");
    sample_in_valid = 1'b1;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    reset_values;
    config_writes;
    sysref_path;
    marker_insert;
    complete_run;
  end
endmodule // tb

bind sysref_clock_fullscale_config sysref_cfg_checker u_sysref_cfg_checker (
  .clock, .rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .reg_rd_valid,
  .marker_output_enable, .decimation_is_one, .sample_in, .sample_in_valid, .sample_out,
  .sysref_captured, .sysref_dc_input_enable, .clock_converter_gain_high, .sample_clock_delay,
  .full_scale_code_a, .full_scale_code_b);

`default_nettype wire
